// >>> include/fcsi_pkg.sv
// Purpose: Constants for the parallel NOR flash command controller
// Assumes: 200 MHz mclk, x16 flash with 19 address lines
// Notes:   Unlock codes sit in the low byte of data; unlock addresses go on flashAddr
package fcsi_pkg;
    localparam int          ADDR_W      = 19;
    localparam int          DATA_W      = 16;
    localparam int          CLK_PS      = 5000;
    // Write pulse low time, well above the glitch floor
    localparam int          WR_LOW_PS   = 40000;
    localparam int          WR_LOW_CYC  = (WR_LOW_PS + CLK_PS - 1) / CLK_PS;
    // Read cycle time, outGateN held low for RD_CYC cycles
    localparam int          RD_CYC_PS   = 90000;
    localparam int          RD_CYC      = (RD_CYC_PS + CLK_PS - 1) / CLK_PS;
    localparam int          GAP_CYC     = 2;
    localparam logic [18:0] ADDR_UNLK1  = 19'h05555;
    localparam logic [18:0] ADDR_UNLK2  = 19'h02aaa;
    localparam logic [7:0]  CODE_UNLK1  = 8'haa;
    localparam logic [7:0]  CODE_UNLK2  = 8'h55;
    localparam logic [7:0]  CODE_PROG   = 8'ha0;
    localparam logic [7:0]  CODE_ERASE  = 8'h80;
    localparam logic [7:0]  CODE_SECT   = 8'h30;
    localparam logic [7:0]  CODE_BLOCK  = 8'h50;
    localparam logic [7:0]  CODE_CHIP   = 8'h10;
    localparam logic [7:0]  CODE_IDENT  = 8'h90;
    localparam logic [7:0]  CODE_QUERY  = 8'h98;
    localparam logic [7:0]  CODE_EXIT   = 8'hf0;
    localparam int          SECT_LSB    = 11;
    localparam int          BLOCK_LSB   = 15;
    localparam int          TOGGLE_BIT  = 6;
    localparam int          POLL_BIT    = 7;
    // Host command codes on cmdOp
    localparam logic [2:0]  OP_READ     = 3'h0;
    localparam logic [2:0]  OP_PROG     = 3'h1;
    localparam logic [2:0]  OP_SECT     = 3'h2;
    localparam logic [2:0]  OP_BLOCK    = 3'h3;
    localparam logic [2:0]  OP_CHIP     = 3'h4;
    localparam logic [2:0]  OP_IDENT    = 3'h5;
    localparam logic [2:0]  OP_QUERY    = 3'h6;
    localparam logic [2:0]  OP_EXIT     = 3'h7;
endpackage

// >>> verilog/fcsi_host.sv
// Purpose: Host controller driving the flash pins for reads and commands
// Assumes: Flash data inputs synchronous to mclk; one request at a time
// Notes:   Busy waits by toggle-bit polling until bit 6 (TOGGLE_BIT) of two successive reads agrees

module fcsi_host #(
    parameter int WR_LOW = fcsi_pkg::WR_LOW_CYC,
    parameter int RD_LEN = fcsi_pkg::RD_CYC
) (
    input  wire logic        mclk,
    input  wire logic        srst,
    input  wire logic        cmdValid,
    input  wire logic [2:0]  cmdOp,
    input  wire logic [18:0] cmdAddr,
    input  wire logic [15:0] cmdData,
    output logic             cmdReady,
    output logic             rspValid,
    output logic [15:0]      rspData,
    output logic [18:0]      flashAddr,
    output logic             chipSelN,
    output logic             writeStrobeN,
    output logic             outGateN,
    input  wire logic [15:0] dataLinesIn,
    output logic [15:0]      dataLinesOut,
    output logic             dataLinesOeN
);
    if (WR_LOW < 2 || RD_LEN < 2 ||
        WR_LOW > 255 || RD_LEN > 255) begin : g_badTiming
        $error("Timing parameters out of range");
    end

    typedef enum logic [2:0] {
        FCSI_IDLE, FCSI_WSET, FCSI_WLOW, FCSI_WHOLD, FCSI_RLOW, FCSI_RGAP
    } fcsi_state_t;

    // Address and data word of the n-th write of a sequence
    function automatic logic [34:0] seqWord(input logic [2:0] op,
                                            input logic [2:0] idx,
                                            input logic [18:0] a,
                                            input logic [15:0] d);
        logic [18:0] wa;
        logic [15:0] wd;
        wa = fcsi_pkg::ADDR_UNLK1;
        wd = {8'h00, fcsi_pkg::CODE_UNLK1};
        case (idx)
            3'h1: begin
                wa = fcsi_pkg::ADDR_UNLK2;
                wd = {8'h00, fcsi_pkg::CODE_UNLK2};
            end
            3'h2: begin
                case (op)
                    fcsi_pkg::OP_PROG:  wd = {8'h00, fcsi_pkg::CODE_PROG};
                    fcsi_pkg::OP_IDENT: wd = {8'h00, fcsi_pkg::CODE_IDENT};
                    fcsi_pkg::OP_QUERY: wd = {8'h00, fcsi_pkg::CODE_QUERY};
                    default:            wd = {8'h00, fcsi_pkg::CODE_ERASE};
                endcase
            end
            3'h3: begin
                if (op == fcsi_pkg::OP_PROG) begin
                    wa = a;
                    wd = d;
                end
            end
            3'h4: begin
                wa = fcsi_pkg::ADDR_UNLK2;
                wd = {8'h00, fcsi_pkg::CODE_UNLK2};
            end
            3'h5: begin
                case (op)
                    fcsi_pkg::OP_SECT: begin
                        wa = {a[18:fcsi_pkg::SECT_LSB], 11'h000};
                        wd = {8'h00, fcsi_pkg::CODE_SECT};
                    end
                    fcsi_pkg::OP_BLOCK: begin
                        wa = {a[18:fcsi_pkg::BLOCK_LSB], 15'h0000};
                        wd = {8'h00, fcsi_pkg::CODE_BLOCK};
                    end
                    default: wd = {8'h00, fcsi_pkg::CODE_CHIP};
                endcase
            end
            default: ;
        endcase
        if (op == fcsi_pkg::OP_EXIT)
            wd = {8'h00, fcsi_pkg::CODE_EXIT};
        return {wa, wd};
    endfunction

    function automatic logic [2:0] seqLen(input logic [2:0] op);
        case (op)
            fcsi_pkg::OP_EXIT:  return 3'h1;
            fcsi_pkg::OP_PROG:  return 3'h4;
            fcsi_pkg::OP_IDENT,
            fcsi_pkg::OP_QUERY: return 3'h3;
            default:            return 3'h6;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------
    fcsi_state_t state_r, state_nxt;
    logic [2:0]  op_r, op_nxt, idx_r, idx_nxt;
    logic [18:0] addr_r, addr_nxt, fAddr_r, fAddr_nxt;
    logic [15:0] wdat_r, wdat_nxt, dOut_r, dOut_nxt;
    logic [15:0] last_r, last_nxt, rsp_r, rsp_nxt;
    logic [7:0]  cnt_r, cnt_nxt;
    logic        poll_r, poll_nxt, havePrev_r, havePrev_nxt;
    logic        cs_r, cs_nxt, we_r, we_nxt, oe_r, oe_nxt, dOe_r, dOe_nxt;
    logic        rdy_r, rdy_nxt, rv_r, rv_nxt;
    logic [34:0] sw;

    always_comb begin
        state_nxt = state_r;
        op_nxt = op_r;
        idx_nxt = idx_r;
        addr_nxt = addr_r;
        wdat_nxt = wdat_r;
        fAddr_nxt = fAddr_r;
        dOut_nxt = dOut_r;
        last_nxt = last_r;
        rsp_nxt = rsp_r;
        cnt_nxt = cnt_r;
        poll_nxt = poll_r;
        havePrev_nxt = havePrev_r;
        cs_nxt = cs_r;
        we_nxt = we_r;
        oe_nxt = oe_r;
        dOe_nxt = dOe_r;
        rdy_nxt = 1'b0;
        rv_nxt = 1'b0;
        sw = seqWord(op_r, idx_r, addr_r, wdat_r);
        case (state_r)
            FCSI_IDLE: begin
                cs_nxt = 1'b1;
                oe_nxt = 1'b1;
                we_nxt = 1'b1;
                dOe_nxt = 1'b1;
                rdy_nxt = 1'b1;
                if (cmdValid && rdy_r) begin
                    rdy_nxt = 1'b0;
                    op_nxt = cmdOp;
                    addr_nxt = cmdAddr;
                    wdat_nxt = cmdData;
                    idx_nxt = 3'h0;
                    havePrev_nxt = 1'b0;
                    cnt_nxt = 8'(RD_LEN);
                    if (cmdOp == fcsi_pkg::OP_READ) begin
                        poll_nxt = 1'b0;
                        fAddr_nxt = cmdAddr;
                        cs_nxt = 1'b0;
                        oe_nxt = 1'b0;
                        state_nxt = FCSI_RLOW;
                    end else begin
                        state_nxt = FCSI_WSET;
                    end
                end
            end
            FCSI_WSET: begin
                fAddr_nxt = sw[34:16];
                dOut_nxt = sw[15:0];
                cs_nxt = 1'b0;
                oe_nxt = 1'b1;
                dOe_nxt = 1'b0;
                cnt_nxt = 8'(WR_LOW);
                state_nxt = FCSI_WLOW;
                we_nxt = 1'b0;
            end
            FCSI_WLOW: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    we_nxt = 1'b1;
                    cnt_nxt = 8'(fcsi_pkg::GAP_CYC);
                    state_nxt = FCSI_WHOLD;
                end
            end
            FCSI_WHOLD: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    cs_nxt = 1'b1;
                    dOe_nxt = 1'b1;
                    if (idx_r + 3'h1 < seqLen(op_r)) begin
                        idx_nxt = idx_r + 3'h1;
                        state_nxt = FCSI_WSET;
                    end else if (op_r == fcsi_pkg::OP_PROG ||
                                 op_r == fcsi_pkg::OP_SECT ||
                                 op_r == fcsi_pkg::OP_BLOCK ||
                                 op_r == fcsi_pkg::OP_CHIP) begin
                        poll_nxt = 1'b1;
                        fAddr_nxt = sw[34:16];
                        cnt_nxt = 8'(RD_LEN);
                        state_nxt = FCSI_RGAP;
                    end else begin
                        cnt_nxt = 8'(RD_LEN);
                        state_nxt = FCSI_RGAP;
                        poll_nxt = 1'b0;
                        rsp_nxt = 16'h0000;
                    end
                end
            end
            FCSI_RLOW: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    cs_nxt = 1'b1;
                    oe_nxt = 1'b1;
                    last_nxt = dataLinesIn;
                    havePrev_nxt = 1'b1;
                    cnt_nxt = 8'(fcsi_pkg::GAP_CYC);
                    state_nxt = FCSI_RGAP;
                    if (!poll_r) begin
                        rsp_nxt = dataLinesIn;
                        rv_nxt = 1'b1;
                        state_nxt = FCSI_IDLE;
                    end else if (havePrev_r &&
                                 dataLinesIn[fcsi_pkg::TOGGLE_BIT] ==
                                 last_r[fcsi_pkg::TOGGLE_BIT]) begin
                        rsp_nxt = dataLinesIn;
                        rv_nxt = 1'b1;
                        state_nxt = FCSI_IDLE;
                    end
                end
            end
            FCSI_RGAP: begin
                cnt_nxt = cnt_r - 8'h01;
                if (cnt_r == 8'h01) begin
                    if (poll_r) begin
                        cs_nxt = 1'b0;
                        oe_nxt = 1'b0;
                        cnt_nxt = 8'(RD_LEN);
                        state_nxt = FCSI_RLOW;
                    end else begin
                        rv_nxt = 1'b1;
                        state_nxt = FCSI_IDLE;
                    end
                end
            end
            default: state_nxt = FCSI_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            state_r <= FCSI_IDLE;
            op_r <= 3'h0;
            idx_r <= 3'h0;
            addr_r <= 19'h00000;
            wdat_r <= 16'h0000;
            fAddr_r <= 19'h00000;
            dOut_r <= 16'h0000;
            last_r <= 16'h0000;
            rsp_r <= 16'h0000;
            cnt_r <= 8'h00;
            poll_r <= 1'b0;
            havePrev_r <= 1'b0;
            cs_r <= 1'b1;
            we_r <= 1'b1;
            oe_r <= 1'b1;
            dOe_r <= 1'b1;
            rdy_r <= 1'b0;
            rv_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            idx_r <= idx_nxt;
            addr_r <= addr_nxt;
            wdat_r <= wdat_nxt;
            fAddr_r <= fAddr_nxt;
            dOut_r <= dOut_nxt;
            last_r <= last_nxt;
            rsp_r <= rsp_nxt;
            cnt_r <= cnt_nxt;
            poll_r <= poll_nxt;
            havePrev_r <= havePrev_nxt;
            cs_r <= cs_nxt;
            we_r <= we_nxt;
            oe_r <= oe_nxt;
            dOe_r <= dOe_nxt;
            rdy_r <= rdy_nxt;
            rv_r <= rv_nxt;
        end
    end

    assign cmdReady     = rdy_r;
    assign rspValid     = rv_r;
    assign rspData      = rsp_r;
    assign flashAddr    = fAddr_r;
    assign chipSelN     = cs_r;
    assign writeStrobeN = we_r;
    assign outGateN     = oe_r;
    assign dataLinesOut = dOut_r;
    assign dataLinesOeN = dOe_r;
endmodule // fcsi_host

// >>> verif/fcsi_host_assertions.sv
// Purpose: Port checks for the flash host controller
// Assumes: Bound to fcsi_host; WR_LOW and RD_LEN handed down
// Notes:   Single clock domain, srst disables every check
module fcsi_host_chk #(
    parameter int WR_LOW = 2,
    parameter int RD_LEN = 2
) (
    input wire logic        mclk,
    input wire logic        srst,
    input wire logic        cmdValid,
    input wire logic [2:0]  cmdOp,
    input wire logic [18:0] cmdAddr,
    input wire logic [15:0] cmdData,
    input wire logic        cmdReady,
    input wire logic        rspValid,
    input wire logic [15:0] rspData,
    input wire logic [18:0] flashAddr,
    input wire logic        chipSelN,
    input wire logic        writeStrobeN,
    input wire logic        outGateN,
    input wire logic [15:0] dataLinesIn,
    input wire logic [15:0] dataLinesOut,
    input wire logic        dataLinesOeN
);
    localparam int RD_RSP = RD_LEN + 1;
    logic take;
    assign take = cmdValid && cmdReady;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    a_strobe_gated: assert property (
        !writeStrobeN |-> outGateN && !chipSelN)
        else $error("Write strobe low without select or with gate");
    a_strobe_width: assert property (
        $fell(writeStrobeN) |-> !writeStrobeN [*2])
        else $error("Write strobe pulse too short");
    a_drive_gate: assert property (
        !dataLinesOeN |-> outGateN)
        else $error("Host drives data while output gate low");
    a_idle_quiet: assert property (
        cmdReady |-> chipSelN && dataLinesOeN)
        else $error("Flash selected while idle");
    a_read_time: assert property (
        take && cmdOp == fcsi_pkg::OP_READ
        |-> ##1 (!chipSelN && !outGateN && flashAddr == $past(cmdAddr))
        ##(RD_RSP - 1) rspValid)
        else $error("Read answer late or pins wrong");
    a_ready_drop: assert property (
        take |=> !cmdReady)
        else $error("Ready stayed high after take");
    a_rsp_pulse: assert property (
        rspValid |=> !rspValid && cmdReady)
        else $error("Response not a single pulse");
    a_unlock_first: assert property (
        take && cmdOp != fcsi_pkg::OP_READ && cmdOp != fcsi_pkg::OP_EXIT
        |-> ##[2:3] (!writeStrobeN && flashAddr == 19'h05555
        && dataLinesOut == 16'h00aa))
        else $error("Command did not start with first unlock write");
    a_exit_single: assert property (
        take && cmdOp == fcsi_pkg::OP_EXIT
        |-> ##[2:3] (!writeStrobeN && dataLinesOut == 16'h00f0))
        else $error("Exit not sent as one F0 write");
    a_strobe_hold: assert property (
        $rose(writeStrobeN) |-> !chipSelN && !dataLinesOeN)
        else $error("Select or data released before strobe rise");
endmodule // fcsi_host_chk
bind fcsi_host fcsi_host_chk #(.WR_LOW(WR_LOW), .RD_LEN(RD_LEN)) u_chk (
    .mclk(mclk), .srst(srst), .cmdValid(cmdValid), .cmdOp(cmdOp),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspData(rspData), .flashAddr(flashAddr),
    .chipSelN(chipSelN), .writeStrobeN(writeStrobeN), .outGateN(outGateN),
    .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
    .dataLinesOeN(dataLinesOeN));

// >>> verif/fcsi_flash_model.sv
// Purpose: Behavioural x16 NOR flash for the host controller bench
// Assumes: Strobe edges frame every access, no clock
// Notes:   Busy time in ns; erase takes three times as long
module fcsi_flash_model #(
    parameter logic [15:0] MAKER_ID = 16'h0a5c, // Arbitrary value
    parameter logic [15:0] PART_ID  = 16'h3c61, // Arbitrary value
    parameter int          BUSY_NS  = 150
) (
    input  wire logic [18:0] flashAddr,
    input  wire logic        chipSelN,
    input  wire logic        writeStrobeN,
    input  wire logic        outGateN,
    input  wire logic [15:0] dataLinesOut,
    output logic      [15:0] dataLinesIn
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] mem [int];
    logic [15:0] rdVal = 16'h0000;
    logic [15:0] progVal = 16'h0000;
    logic [18:0] aLat;
    int          step = 0;
    int          mode = 0;
    int          sh;
    bit          erasing, tog;
    realtime     tFall, busyEnd = 0;
    assign dataLinesIn = (!chipSelN && !outGateN) ?
        rdVal : ~rdVal;
    always @(negedge outGateN) begin
        #0.5;
        if (!chipSelN && !outGateN) begin
            if ($realtime < busyEnd) begin
                tog = ~tog;
                rdVal = {8'h00, erasing ? 1'b0 : ~progVal[7],
                         tog, 6'h00};
            end else if (mode == 1)
                rdVal = (flashAddr == 19'h1) ? PART_ID : MAKER_ID;
            else if (mode == 2)
                rdVal = (flashAddr == 19'h10) ? 16'h0051 : 16'h0000;
            else
                rdVal = mem.exists(flashAddr) ?
                        mem[flashAddr] : 16'hffff;
        end
    end
    always @(negedge writeStrobeN) begin
        tFall = $realtime;
        #0.5;
        aLat = flashAddr;
    end
    always @(posedge writeStrobeN) begin
        if (!chipSelN && outGateN && $realtime - tFall >= 5.0
            && $realtime >= busyEnd)
            doWrite(aLat, dataLinesOut[7:0]);
    end
    task automatic doWrite(input logic [18:0] a, input logic [7:0] c);
        if (step == 3) begin
            mem[a] = (mem.exists(a) ? mem[a] : 16'hffff) & dataLinesOut;
            progVal = dataLinesOut;
            erasing = 0;
            busyEnd = $realtime + BUSY_NS;
            step = 0;
        end else if (c == 8'hf0) begin
            mode = 0;
            step = 0;
        end else if (step == 0 || step == 4)
            step = (a == 19'h05555 && c == 8'haa) ?
                   step + 1 : 0;
        else if (step == 1 || step == 5)
            step = (a == 19'h02aaa && c == 8'h55) ?
                   step + 1 : 0;
        else if (step == 2) begin
            step = (a != 19'h05555) ? 0 : (c == 8'ha0) ? 3 :
                   (c == 8'h80) ? 4 : 0;
            if (a == 19'h05555 && c == 8'h90)
                mode = 1;
            if (a == 19'h05555 && c == 8'h98)
                mode = 2;
        end else begin
            step = 0;
            sh = (c == 8'h30) ? 11 : (c == 8'h50) ? 15 : 19;
            if (c == 8'h30 || c == 8'h50 ||
                (c == 8'h10 && a == 19'h05555)) begin
                foreach (mem[k])
                    if ((k >> sh) == (int'(a) >> sh))
                        mem[k] = 16'hffff;
                erasing = 1;
                busyEnd = $realtime + 3 * BUSY_NS;
            end
        end
    endtask
endmodule // fcsi_flash_model

// >>> verif/tb_top.sv
// Purpose: Self-checking bench for the flash host controller
// Assumes: Short WR_LOW and RD_LEN of 2 cycles
// Notes:   Expected array kept in a shadow map
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [15:0] MAKER = 16'h0a5c; // Arbitrary value
    localparam logic [15:0] PART  = 16'h3c61; // Arbitrary value
    logic        mclk = 0, srst = 1, cmdValid = 0;
    logic [2:0]  cmdOp = 0;
    logic [18:0] cmdAddr = 0, flashAddr, a;
    logic [15:0] cmdData = 0, rspData, dataLinesIn, dataLinesOut, got;
    logic        cmdReady, rspValid, chipSelN, writeStrobeN;
    logic        outGateN, dataLinesOeN;
    logic [15:0] shadow [int];
    int          fails = 0, compares = 0;
    always #2.5 mclk = ~mclk;
    fcsi_host #(.WR_LOW(2), .RD_LEN(2)) u_dut (.mclk(mclk), .srst(srst),
        .cmdValid(cmdValid), .cmdOp(cmdOp), .cmdAddr(cmdAddr),
        .cmdData(cmdData), .cmdReady(cmdReady), .rspValid(rspValid),
        .rspData(rspData), .flashAddr(flashAddr), .chipSelN(chipSelN),
        .writeStrobeN(writeStrobeN), .outGateN(outGateN),
        .dataLinesIn(dataLinesIn), .dataLinesOut(dataLinesOut),
        .dataLinesOeN(dataLinesOeN));
    fcsi_flash_model #(.MAKER_ID(MAKER), .PART_ID(PART)) u_flash (
        .flashAddr(flashAddr), .chipSelN(chipSelN),
        .writeStrobeN(writeStrobeN), .outGateN(outGateN),
        .dataLinesOut(dataLinesOut), .dataLinesIn(dataLinesIn));
    function automatic logic [15:0] expWord(input logic [18:0] ad);
        return shadow.exists(ad) ? shadow[ad] : 16'hffff;
    endfunction
    task automatic check(input string what, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic run(input logic [2:0] op, input logic [18:0] ad,
                       input logic [15:0] dt);
        int n;
        @(posedge mclk);
        cmdValid <= 1'b1;
        cmdOp <= op;
        cmdAddr <= ad;
        cmdData <= dt;
        n = 0;
        do @(posedge mclk); while (cmdReady !== 1'b1 && ++n < 100);
        cmdValid <= 1'b0;
        n = 0;
        do @(posedge mclk); while (rspValid !== 1'b1 && ++n < 4000);
        got = rspData;
        if (rspValid !== 1'b1) begin
            fails++;
            wrap_up();
        end
    endtask
    task automatic rdChk(input logic [18:0] ad, input logic [15:0] e);
        run(fcsi_pkg::OP_READ, ad, 16'h0000);
        check("read data", e, got);
    endtask
    task automatic prog(input logic [18:0] ad, input logic [15:0] dt);
        run(fcsi_pkg::OP_PROG, ad, dt);
        shadow[ad] = expWord(ad) & dt;
        check("poll result", expWord(ad), got);
        rdChk(ad, expWord(ad));
    endtask
    task automatic er(input logic [2:0] op, input logic [18:0] ad,
                      input int sh);
        run(op, ad, 16'h0000);
        foreach (shadow[k])
            if ((k >> sh) == (int'(ad) >> sh))
                shadow[k] = 16'hffff;
        check("erase result", 16'hffff, got);
        rdChk(ad, expWord(ad));
    endtask
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        repeat (50000) @(posedge mclk);
        fails++;
        wrap_up();
    end
    initial begin
        void'($urandom(58));
        repeat (3) @(posedge mclk);
        srst <= 1'b0;
        rdChk(19'h00000, 16'hffff);
        for (int i = 0; i < 8; i++) begin
            a = (i == 0) ? 19'h7ffff : 19'($urandom);
            got = (i == 1) ? 16'h0000 : 16'($urandom);
            prog(a, got);
        end
        $display("Test program done");
        prog(19'h12345, 16'h1234);
        prog(19'h12b45, 16'h5678);
        er(fcsi_pkg::OP_SECT, 19'h12345, 11);
        rdChk(19'h12b45, 16'h5678);
        er(fcsi_pkg::OP_BLOCK, 19'h10000, 15);
        rdChk(19'h12b45, 16'hffff);
        prog(19'h00001, 16'h00aa);
        er(fcsi_pkg::OP_CHIP, 19'h05555, 19);
        rdChk(19'h00001, 16'hffff);
        $display("Test erase done");
        prog(19'h00000, 16'h0f0f);
        run(fcsi_pkg::OP_IDENT, 19'h0, 16'h0);
        check("entry status", 16'h0000, got);
        rdChk(19'h00000, MAKER);
        rdChk(19'h00001, PART);
        run(fcsi_pkg::OP_EXIT, 19'h0, 16'h0);
        rdChk(19'h00000, 16'h0f0f);
        run(fcsi_pkg::OP_QUERY, 19'h0, 16'h0);
        rdChk(19'h00010, 16'h0051);
        rdChk(19'h00000, 16'h0000);
        run(fcsi_pkg::OP_EXIT, 19'h0, 16'h0);
        rdChk(19'h00000, 16'h0f0f);
        run(fcsi_pkg::OP_EXIT, 19'h0, 16'h0);
        rdChk(19'h00000, 16'h0f0f);
        $display("Test modes done");
        wrap_up();
    end
endmodule // tb_top
